// file: include/bmst_pkg.sv
// package: constants, types and helpers of the buffer memory self-test block
// Contract
// R1 - a running test writes every location of the 8-Kbyte buffer
// R2 - host starts a test only after reset or once traffic hardware is free
// R3 - host keeps dma_start, receive_enable and transmit_request clear during a test
// R4 - control, fill seed and split high/low result checksum registers are provided
// R5 - seed is the literal pattern or the random generator start, per mode
// R6 - control bits 3:2 pick fill: 00 random, 01 address, 10 shift; 11 reserved
// R7 - shift mode rotates the seed left by control bits 7:5 after each write
// R8 - control bit 4 set swaps the buffer ports of self-test and DMA
// R9 - bit 0 starts a test and reads one while filling, zero otherwise
// R10 - no fill happens unless test mode enable, control bit 1, is set
// R11 - start/busy bit clears itself when fill and checksum are done
// R12 - on completion the computed checksum loads into the result register pair
// R13 - address fill stores the low address byte in each location
// R14 - random fill uses an LFSR from the seed; final state stays in seed
// R15 - host clearing start/busy mid-fill stops writing and returns to idle
package bmst_pkg;
    localparam int BMST_ADDR_W = 13;
    localparam logic [12:0] BMST_LAST_ADDR = 13'h1fff;
    // register byte offsets on the bus
    localparam logic [7:0] BMST_OFF_CTRL = 8'h00;
    localparam logic [7:0] BMST_OFF_SEED = 8'h04;
    localparam logic [7:0] BMST_OFF_CSUM_LO = 8'h08;
    localparam logic [7:0] BMST_OFF_CSUM_HI = 8'h0c;
    localparam logic [7:0] BMST_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] BMST_OFF_IRQ_MASK = 8'h14;
    // control field positions
    localparam int BMST_BIT_START = 0;
    localparam int BMST_BIT_TME = 1;
    localparam int BMST_MODE_LSB = 2;
    localparam int BMST_BIT_PSEL = 4;
    localparam int BMST_SHIFT_LSB = 5;
    // fill modes
    localparam logic [1:0] BMST_MODE_RANDOM = 2'h0;
    localparam logic [1:0] BMST_MODE_ADDR = 2'h1;
    localparam logic [1:0] BMST_MODE_SHIFT = 2'h2;
    localparam logic [1:0] BMST_MODE_RSVD = 2'h3;
    // interrupt status bits
    localparam int BMST_IRQ_DONE = 0;
    localparam int BMST_IRQ_ABORT = 1;
    // reset values
    localparam logic [7:0] BMST_CTRL_RST = 8'h00;
    localparam logic [7:0] BMST_SEED_RST = 8'h00;
    localparam logic [15:0] BMST_CSUM_RST = 16'h0000;
    localparam logic [1:0] BMST_IRQ_RST = 2'h0;

    typedef enum logic {BMST_IDLE, BMST_FILL} bmst_state_type;

    typedef struct packed {
        logic en;
        logic we;
        logic [12:0] addr;
        logic [7:0] wdata;
    } bmst_port_type;

    localparam bmst_port_type BMST_PORT_IDLE = '{en: 1'b0, we: 1'b0, addr: 13'h0000, wdata: 8'h00};

    // galois-free fibonacci step, taps 8,6,5,4; zero stays zero
    function automatic logic [7:0] bmst_lfsr_step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] bmst_rotl(input logic [7:0] s, input logic [2:0] n);
        logic [15:0] d;
        d = {s, s} << n;
        return d[15:8];
    endfunction

    // ones-complement add with end-around carry
    function automatic logic [15:0] bmst_ones_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        return t[15:0] + {15'h0000, t[16]};
    endfunction
endpackage

// file: rtl/bmst_pattern.sv
// fill byte generator and seed update for each fill mode
`timescale 1ns/100ps
module bmst_pattern
    import bmst_pkg::*;
(
    input wire logic [1:0] mode, // fill mode
    input wire logic [2:0] shift, // rotate amount
    input wire logic [7:0] seed, // current seed state
    input wire logic [7:0] addr_lo, // low address byte
    output logic [7:0] fill_byte, // byte to write
    output logic [7:0] seed_next // seed after this write
);
    always_comb begin
        fill_byte = seed; // R5
        seed_next = seed;
        unique case (mode)
            BMST_MODE_RANDOM: seed_next = bmst_lfsr_step(seed); // R14
            BMST_MODE_ADDR: fill_byte = addr_lo; // R13
            BMST_MODE_SHIFT: seed_next = bmst_rotl(seed, shift); // R7
            default: fill_byte = seed;
        endcase
    end
endmodule

// file: rtl/bmst_cksum.sv
// running 16-bit ones-complement checksum over written bytes
`timescale 1ns/100ps
module bmst_cksum
    import bmst_pkg::*;
(
    input wire logic ref_clk, // main clock
    input wire logic rst_n, // sync reset, active low
    input wire logic clear, // restart the sum
    input wire logic valid, // byte written this cycle
    input wire logic odd, // byte is the low half of a word
    input wire logic [7:0] data, // byte written
    output logic [15:0] total // final checksum including this odd byte
);
    logic [15:0] acc_reg, acc_next;
    logic [7:0] hi_reg, hi_next;

    always_comb begin
        acc_next = acc_reg;
        hi_next = hi_reg;
        if (clear) begin
            acc_next = 16'h0000;
            hi_next = 8'h00;
        end else if (valid && !odd) begin
            hi_next = data;
        end else if (valid) begin
            acc_next = bmst_ones_add(acc_reg, {hi_reg, data});
        end
    end

    // even byte count, so the final word is always complete
    assign total = ~bmst_ones_add(acc_reg, {hi_reg, data});

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_reg <= 16'h0000;
            hi_reg <= 8'h00;
        end else begin
            acc_reg <= acc_next;
            hi_reg <= hi_next;
        end
    end
endmodule

// file: rtl/bmst_top.sv
// self-test controller for the dual-port packet buffer, wishbone register slave
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module bmst_top
    import bmst_pkg::*;
(
    input wire logic ref_clk, // main clock
    input wire logic rst_n, // sync reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // write enable
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire bmst_port_type dma_port_i, // dma engine buffer request
    output bmst_port_type port_a_o, // buffer port a
    output bmst_port_type port_b_o, // buffer port b
    input wire logic [7:0] port_a_rdata, // port a read data
    input wire logic [7:0] port_b_rdata, // port b read data
    output logic [7:0] dma_rdata_o, // read data routed to dma
    output logic irq_o // level interrupt
);
    bmst_state_type state_reg, state_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] seed_reg, seed_next;
    logic [15:0] csum_reg, csum_next;
    logic [12:0] addr_reg, addr_next;
    bmst_port_type bist_reg, bist_next;
    logic [1:0] irq_stat_reg, irq_stat_next;
    logic [1:0] irq_mask_reg, irq_mask_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;

    logic busy, req, wr_fire, rd_take, lane0;
    logic start_ok, abort, last;
    logic [7:0] fill_byte, seed_step, ctrl_rd;
    logic [15:0] csum_total;
    logic [1:0] mode;

    assign busy = (state_reg == BMST_FILL);
    assign mode = ctrl_reg[BMST_MODE_LSB +: 2];
    assign req = wb_cyc_i && wb_stb_i;
    // write lands on the edge at which the master samples ack
    assign wr_fire = req && ack_reg && wb_we_i;
    assign rd_take = req && !ack_reg;
    assign lane0 = wb_sel_i[0];
    assign ctrl_rd = {ctrl_reg[7:1], busy}; // R9

    bmst_pattern u_pattern (
        .mode(mode),
        .shift(ctrl_reg[BMST_SHIFT_LSB +: 3]),
        .seed(seed_reg),
        .addr_lo(addr_reg[7:0]),
        .fill_byte(fill_byte),
        .seed_next(seed_step)
    );

    bmst_cksum u_cksum (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(!busy),
        .valid(busy),
        .odd(addr_reg[0]),
        .data(fill_byte),
        .total(csum_total)
    );

    // control writes: start and abort decode
    always_comb begin
        start_ok = 1'b0;
        abort = 1'b0;
        if (wr_fire && lane0 && wb_adr_i == BMST_OFF_CTRL) begin
            start_ok = !busy && wb_dat_i[BMST_BIT_START] && wb_dat_i[BMST_BIT_TME] // R10
                && wb_dat_i[BMST_MODE_LSB +: 2] != BMST_MODE_RSVD; // R6
            abort = busy && (!wb_dat_i[BMST_BIT_START] || !wb_dat_i[BMST_BIT_TME]); // R15
        end
    end

    assign last = busy && addr_reg == BMST_LAST_ADDR;

    // fill engine
    always_comb begin
        state_next = state_reg;
        ctrl_next = ctrl_reg;
        seed_next = seed_reg;
        csum_next = csum_reg;
        addr_next = addr_reg;
        bist_next = BMST_PORT_IDLE;
        if (wr_fire && lane0 && wb_adr_i == BMST_OFF_CTRL) begin
            if (!busy) begin
                ctrl_next = {wb_dat_i[7:1], 1'b0};
            end else begin
                ctrl_next[BMST_BIT_TME] = wb_dat_i[BMST_BIT_TME];
            end
        end
        // seed is owned by the fill while busy
        if (wr_fire && lane0 && wb_adr_i == BMST_OFF_SEED && !busy) begin
            seed_next = wb_dat_i[7:0];
        end
        unique case (state_reg)
            BMST_IDLE: begin
                if (start_ok) begin
                    state_next = BMST_FILL;
                    addr_next = 13'h0000;
                end
            end
            BMST_FILL: begin
                if (abort) begin
                    state_next = BMST_IDLE; // R15
                end else begin
                    bist_next = '{en: 1'b1, we: 1'b1, addr: addr_reg, wdata: fill_byte}; // R1
                    seed_next = seed_step; // R14
                    addr_next = addr_reg + 13'h0001; // R1
                    if (last) begin
                        state_next = BMST_IDLE; // R11
                        csum_next = csum_total; // R12
                    end
                end
            end
        endcase
    end

    // interrupt status, cleared by a read, set wins
    always_comb begin
        irq_stat_next = irq_stat_reg;
        irq_mask_next = irq_mask_reg;
        if (rd_take && !wb_we_i && wb_adr_i == BMST_OFF_IRQ_STAT) begin
            irq_stat_next = 2'h0;
        end
        if (busy && !abort && last) begin
            irq_stat_next[BMST_IRQ_DONE] = 1'b1;
        end
        if (abort) begin
            irq_stat_next[BMST_IRQ_ABORT] = 1'b1;
        end
        if (wr_fire && lane0 && wb_adr_i == BMST_OFF_IRQ_MASK) begin
            irq_mask_next = wb_dat_i[1:0];
        end
    end

    // bus answer: one wait cycle, unmapped reads return zero
    always_comb begin
        ack_next = req && !ack_reg;
        dat_next = dat_reg;
        if (rd_take) begin
            unique case (wb_adr_i)
                BMST_OFF_CTRL: dat_next = {24'h000000, ctrl_rd};
                BMST_OFF_SEED: dat_next = {24'h000000, seed_reg};
                BMST_OFF_CSUM_LO: dat_next = {24'h000000, csum_reg[7:0]}; // R4
                BMST_OFF_CSUM_HI: dat_next = {24'h000000, csum_reg[15:8]}; // R4
                BMST_OFF_IRQ_STAT: dat_next = {30'h00000000, irq_stat_reg};
                BMST_OFF_IRQ_MASK: dat_next = {30'h00000000, irq_mask_reg};
                default: dat_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= BMST_IDLE;
            ctrl_reg <= BMST_CTRL_RST;
            seed_reg <= BMST_SEED_RST;
            csum_reg <= BMST_CSUM_RST;
            addr_reg <= 13'h0000;
            bist_reg <= BMST_PORT_IDLE;
            irq_stat_reg <= BMST_IRQ_RST;
            irq_mask_reg <= BMST_IRQ_RST;
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            seed_reg <= seed_next;
            csum_reg <= csum_next;
            addr_reg <= addr_next;
            bist_reg <= bist_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    // port routing; the swap lets each port see both engines
    always_comb begin
        if (ctrl_reg[BMST_BIT_PSEL]) begin
            port_a_o = dma_port_i; // R8
            port_b_o = bist_reg; // R8
            dma_rdata_o = port_a_rdata;
        end else begin
            port_a_o = bist_reg;
            port_b_o = dma_port_i;
            dma_rdata_o = port_b_rdata;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq_o = |(irq_stat_reg & irq_mask_reg);

    property p_full_sweep;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(busy) |-> addr_reg == 13'h0000 ##1 (bist_reg.addr == 13'h0000 || !busy);
    endproperty
    a_full_sweep: assert property (p_full_sweep) else $error("fill did not begin at address zero"); // R1

    property p_seed_literal;
        @(posedge ref_clk) disable iff (!rst_n)
        busy && !abort && mode != BMST_MODE_ADDR |=> bist_reg.wdata == $past(seed_reg);
    endproperty
    a_seed_literal: assert property (p_seed_literal) else $error("fill byte is not the seed state"); // R5

    property p_rsvd_mode;
        @(posedge ref_clk) disable iff (!rst_n)
        busy |-> mode != BMST_MODE_RSVD;
    endproperty
    a_rsvd_mode: assert property (p_rsvd_mode) else $error("fill running in reserved mode"); // R6

    property p_shift;
        @(posedge ref_clk) disable iff (!rst_n)
        busy && !abort && mode == BMST_MODE_SHIFT |=>
            seed_reg == bmst_rotl($past(seed_reg), $past(ctrl_reg[7:5]));
    endproperty
    a_shift: assert property (p_shift) else $error("seed not rotated after write"); // R7

    property p_swap;
        @(posedge ref_clk) disable iff (!rst_n)
        ctrl_reg[BMST_BIT_PSEL] |-> port_a_o == dma_port_i && port_b_o == bist_reg;
    endproperty
    a_swap: assert property (p_swap) else $error("ports not swapped"); // R8

    property p_busy_read;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_take && !wb_we_i && wb_adr_i == BMST_OFF_CTRL |=> wb_dat_o[0] == $past(busy);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("start/busy bit misreported"); // R9

    property p_enable;
        @(posedge ref_clk) disable iff (!rst_n)
        bist_reg.we |-> ctrl_reg[BMST_BIT_TME];
    endproperty
    a_enable: assert property (p_enable) else $error("fill without test mode enable"); // R10

    property p_auto_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        last && !abort |=> !busy && bist_reg.addr == BMST_LAST_ADDR && csum_reg == $past(csum_total);
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("completion not taken"); // R11 R12

    property p_addr_fill;
        @(posedge ref_clk) disable iff (!rst_n)
        bist_reg.we && mode == BMST_MODE_ADDR |-> bist_reg.wdata == bist_reg.addr[7:0];
    endproperty
    a_addr_fill: assert property (p_addr_fill) else $error("address fill byte wrong"); // R13

    property p_random;
        @(posedge ref_clk) disable iff (!rst_n)
        busy && !abort && mode == BMST_MODE_RANDOM |=> seed_reg == bmst_lfsr_step($past(seed_reg));
    endproperty
    a_random: assert property (p_random) else $error("generator did not step"); // R14

    property p_abort;
        @(posedge ref_clk) disable iff (!rst_n)
        abort |=> !busy && !bist_reg.we ##1 !bist_reg.we;
    endproperty
    a_abort: assert property (p_abort) else $error("fill continued after cancel"); // R15

    property p_csum_hi;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_take && !wb_we_i && wb_adr_i == BMST_OFF_CSUM_HI |=> wb_ack_o && wb_dat_o[7:0] == $past(csum_reg[15:8]);
    endproperty
    a_csum_hi: assert property (p_csum_hi) else $error("checksum high byte misread"); // R4
endmodule

// file: bench/bmst_top_bench.sv
// self-checking bench for the buffer memory self-test block
`timescale 1ns/100ps
module bmst_top_bench
    import bmst_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    bmst_port_type dma_port_i = BMST_PORT_IDLE;
    bmst_port_type port_a_o;
    bmst_port_type port_b_o;
    logic [7:0] port_a_rdata = 8'h3c;
    logic [7:0] port_b_rdata = 8'hc3;
    logic [7:0] dma_rdata_o;
    logic irq_o;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_wr = 0;
    int hold_wr;
    logic [1:0] mon_mode = 2'h0;
    logic [2:0] mon_shift = 3'h0;
    logic mon_psel = 1'b0;
    logic mon_on = 1'b0;
    logic [7:0] mon_seed = 8'h00;
    logic [7:0] mon_hi = 8'h00;
    logic [7:0] exp_byte;
    logic [12:0] mon_addr = 13'h0000;
    logic [15:0] mon_sum = 16'h0000;
    logic [15:0] rot;
    logic [16:0] t17;
    logic [31:0] rd;
    bmst_port_type st;
    bmst_port_type dt;

    bmst_top i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .dma_port_i(dma_port_i), .port_a_o(port_a_o), .port_b_o(port_b_o),
        .port_a_rdata(port_a_rdata), .port_b_rdata(port_b_rdata), .dma_rdata_o(dma_rdata_o), .irq_o(irq_o)
    );

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // classic single cycle; release only at the edge that saw ack
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        int i;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, wd};
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            final_report();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 8'h00);
        check(rd, exp);
    endtask

    task automatic run_fill(input logic [7:0] ctrl, input logic [7:0] seed);
        mon_mode = ctrl[3:2];
        mon_shift = ctrl[7:5];
        mon_psel = ctrl[4];
        mon_seed = seed;
        mon_addr = 13'h0000;
        mon_sum = 16'h0000;
        n_wr = 0;
        xfer(1'b1, BMST_OFF_SEED, seed);
        xfer(1'b1, BMST_OFF_CTRL, ctrl);
        rd_chk(BMST_OFF_CTRL, {24'h0, ctrl});
        mon_on = 1'b1;
    endtask

    // polls busy; the fill is 8192 cycles, each poll three or more
    task automatic wait_idle();
        int i;
        for (i = 0; i < 4000; i++) begin
            xfer(1'b0, BMST_OFF_CTRL, 8'h00);
            if (rd[0] === 1'b0) break;
        end
        if (i == 4000) begin
            n_mismatch++;
            final_report();
        end
        mon_on = 1'b0;
    endtask

    assign st = mon_psel ? port_b_o : port_a_o;
    assign dt = mon_psel ? port_a_o : port_b_o;
    assign exp_byte = (mon_mode == BMST_MODE_ADDR) ? mon_addr[7:0] : mon_seed;

    // dma side only reads, so its requests never count as fill writes
    always @(posedge ref_clk) begin
        dma_port_i <= '{en: 1'b1, we: 1'b0, addr: mon_addr + 13'h0005, wdata: ~mon_addr[7:0]};
        if (mon_on) begin
            check(dt, dma_port_i);
            check(dma_rdata_o, mon_psel ? port_a_rdata : port_b_rdata);
        end
        if (rst_n && st.en && st.we) begin
            check(st.addr, mon_addr);
            check(st.wdata, exp_byte);
            if (mon_addr[0] == 1'b0) begin
                mon_hi = exp_byte;
            end else begin
                t17 = {1'b0, mon_sum} + {1'b0, mon_hi, exp_byte};
                mon_sum = t17[15:0] + {15'h0000, t17[16]};
            end
            rot = {mon_seed, mon_seed} << mon_shift;
            if (mon_mode == BMST_MODE_RANDOM) begin
                mon_seed = {mon_seed[6:0], mon_seed[7] ^ mon_seed[5] ^ mon_seed[4] ^ mon_seed[3]};
            end else if (mon_mode == BMST_MODE_SHIFT) begin
                mon_seed = rot[15:8];
            end
            mon_addr = mon_addr + 13'h0001;
            n_wr++;
        end
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(BMST_OFF_CTRL, 32'h0);
        rd_chk(BMST_OFF_SEED, 32'h0);
        rd_chk(BMST_OFF_CSUM_LO, 32'h0);
        rd_chk(BMST_OFF_CSUM_HI, 32'h0);
        rd_chk(BMST_OFF_IRQ_STAT, 32'h0);
        rd_chk(BMST_OFF_IRQ_MASK, 32'h0);
        rd_chk(8'h20, 32'h0);
        xfer(1'b1, BMST_OFF_IRQ_MASK, 8'h03);
        rd_chk(BMST_OFF_IRQ_MASK, 32'h3);
        // start without enable, then reserved mode: neither may fill
        xfer(1'b1, BMST_OFF_CTRL, 8'h01);
        rd_chk(BMST_OFF_CTRL, 32'h0);
        xfer(1'b1, BMST_OFF_CTRL, 8'h0f);
        rd_chk(BMST_OFF_CTRL, 32'h0e);
        check(n_wr, 0);
        // first test straight after reset, while the dma side keeps issuing reads every cycle
        run_fill(8'h07, 8'ha5);
        wait_idle();
        check(n_wr, 8192);
        check(irq_o, 1'b1);
        rd_chk(BMST_OFF_CSUM_LO, 32'h07);
        rd_chk(BMST_OFF_CSUM_HI, 32'hf8);
        // complement inside a concat, else the 32-bit argument widens it with ones
        check({16'h0000, ~mon_sum}, 32'h0000f807);
        rd_chk(BMST_OFF_SEED, 32'ha5);
        rd_chk(BMST_OFF_IRQ_STAT, 32'h1);
        check(irq_o, 1'b0);
        rd_chk(BMST_OFF_IRQ_STAT, 32'h0);
        run_fill(8'h7b, 8'h96);
        wait_idle();
        check(n_wr, 8192);
        rd_chk(BMST_OFF_SEED, {24'h0, mon_seed});
        rd_chk(BMST_OFF_CSUM_LO, {24'h0, ~mon_sum[7:0]});
        rd_chk(BMST_OFF_CSUM_HI, {24'h0, ~mon_sum[15:8]});
        run_fill(8'h03, 8'h01);
        wait_idle();
        rd_chk(BMST_OFF_SEED, {24'h0, mon_seed});
        rd_chk(BMST_OFF_CSUM_LO, {24'h0, ~mon_sum[7:0]});
        rd_chk(BMST_OFF_IRQ_STAT, 32'h1);
        // abort mid-fill; a seed write while busy must be ignored
        run_fill(8'h03, 8'h5a);
        xfer(1'b1, BMST_OFF_SEED, 8'hff);
        mon_on = 1'b0;
        xfer(1'b1, BMST_OFF_CTRL, 8'h00);
        rd_chk(BMST_OFF_CTRL, 32'h0);
        hold_wr = n_wr;
        repeat (20) @(posedge ref_clk);
        check(n_wr, hold_wr);
        check(n_wr < 8192, 1'b1);
        rd_chk(BMST_OFF_SEED, {24'h0, mon_seed});
        rd_chk(BMST_OFF_IRQ_STAT, 32'h2);
        final_report();
    end
endmodule
